// file: hdl/wdt_core.sv
// watchdog counter with sleep wake, reset request and AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_core
	import wdt_pkg::*;
#(
	parameter int TICK_CYCLES = `WDT_TICK_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  watchdog_mode_config,
	input  wire logic        clear_watchdog_instruction,
	input  wire logic        sleep_active,
	input  wire logic        osc_fail,
	input  wire logic [3:0]  oscillator_divider_select,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic        wdt_reset_req,
	output var  logic        wake_req,
	output var  logic        irq
);
	logic                          tick;
	logic [`WDT_PRESCALE_W-1:0]    timeout_prescale_select;
	logic                          software_watchdog_enable;
	logic [27:0]                   wdt_count;
	logic                          sleep_d;
	logic                          timeout_flag;
	logic                          powerdown_flag;
	logic                          watchdog_reset_flag;
	logic [1:0]                    int_stat;
	logic [1:0]                    int_mask;
	logic                          wdt_active;
	logic                          expire;
	logic                          clear_cnt;
	logic [27:0]                   limit;
	logic                          aw_hold;
	logic                          w_hold;
	logic [7:0]                    aw_addr;
	logic [31:0]                   w_data;
	logic [3:0]                    w_strb;
	logic                          wr_go;
	logic                          rd_go;
	logic                          stat_rd;
	logic                          int_rd;
	logic [31:0]                   next_rdata;
	wdt_mode_t                     mode;
	wdt_state_t                    state;

	wdt_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tick     (tick)
	);

	assign mode = wdt_mode_t'(watchdog_mode_config);

	always_comb begin
		case (mode)
			MODE_ALWAYS:   wdt_active = 1'b1;
			MODE_AWAKE:    wdt_active = ~sleep_active;
			MODE_SOFTWARE: wdt_active = software_watchdog_enable;
			MODE_OFF:      wdt_active = 1'b0;
			default:       wdt_active = 1'b0;
		endcase
	end

	// period = 2^select ms, select 0 -> 1 ms, select 18 -> 262.144 s
	assign limit = 28'h0000001 << timeout_prescale_select;

	// divider select deliberately not in this term
	assign clear_cnt = clear_watchdog_instruction | osc_fail | ~wdt_active
		| (sleep_active ^ sleep_d);
	// a clear in the same cycle wins over the expiry
	assign expire = (state == ST_COUNT) && tick && !clear_cnt
		&& (wdt_count == limit - 28'h0000001);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_d <= 1'b0;
		end else begin
			sleep_d <= sleep_active;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state     <= ST_IDLE;
			wdt_count <= 28'h0000000;
		end else if (clear_cnt) begin
			wdt_count <= 28'h0000000;
			state     <= wdt_active ? ST_COUNT : ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:  state <= ST_COUNT;
				ST_COUNT: begin
					if (expire) begin
						state     <= ST_FIRED;
						wdt_count <= 28'h0000000;
					end else if (tick) begin
						wdt_count <= wdt_count + 28'h0000001;
					end
				end
				ST_FIRED: state <= ST_COUNT;
				default:  state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdt_reset_req <= 1'b0;
			wake_req      <= 1'b0;
		end else begin
			wdt_reset_req <= expire & ~sleep_active;
			wake_req      <= expire & sleep_active;
		end
	end

	// status flags: all raised by reset, timeout and powerdown by clear; expiry lowers timeout and, in sleep, powerdown, else wdreset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			timeout_flag        <= 1'b1;
			powerdown_flag      <= 1'b1;
			watchdog_reset_flag <= 1'b1;
		end else if (expire) begin
			timeout_flag        <= 1'b0;
			powerdown_flag      <= ~sleep_active;
			watchdog_reset_flag <= sleep_active;
		end else if (clear_watchdog_instruction) begin
			timeout_flag   <= 1'b1;
			powerdown_flag <= 1'b1;
		end
	end

	// bus write channel
	assign wr_go = aw_hold & w_hold & ~s_axi_bvalid;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == `WDT_CTRL_OFS || aw_addr == `WDT_INT_MASK_OFS
					|| aw_addr == `WDT_STAT_OFS || aw_addr == `WDT_INT_STAT_OFS) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			timeout_prescale_select  <= `WDT_PRESCALE_RESET;
			software_watchdog_enable <= 1'b0;
			int_mask                 <= 2'b00;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == `WDT_CTRL_OFS) begin
				software_watchdog_enable <= w_data[`WDT_SWEN_BIT];
				if (w_data[`WDT_PRESCALE_LSB +: `WDT_PRESCALE_W] <= `WDT_PRESCALE_MAX)
					timeout_prescale_select <= w_data[`WDT_PRESCALE_LSB +: `WDT_PRESCALE_W];
			end
			if (aw_addr == `WDT_INT_MASK_OFS)
				int_mask <= w_data[1:0];
		end
	end

	// bus read channel
	assign rd_go   = s_axi_arvalid & s_axi_arready;
	assign stat_rd = rd_go && (s_axi_araddr == `WDT_INT_STAT_OFS);
	always_comb begin
		next_rdata = 32'h00000000;
		case (s_axi_araddr)
			`WDT_CTRL_OFS: begin
				next_rdata[`WDT_SWEN_BIT] = software_watchdog_enable;
				next_rdata[`WDT_PRESCALE_LSB +: `WDT_PRESCALE_W] = timeout_prescale_select;
			end
			`WDT_STAT_OFS: begin
				next_rdata[`WDT_STAT_TIMEOUT]   = timeout_flag;
				next_rdata[`WDT_STAT_POWERDOWN] = powerdown_flag;
				next_rdata[`WDT_STAT_WDRESET]   = watchdog_reset_flag;
				next_rdata[8]                   = wdt_active;
			end
			`WDT_INT_STAT_OFS: next_rdata[1:0] = int_stat;
			`WDT_INT_MASK_OFS: next_rdata[1:0] = int_mask;
			default:           next_rdata = 32'h00000000;
		endcase
	end

	assign int_rd = stat_rd;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= (s_axi_araddr == `WDT_CTRL_OFS || s_axi_araddr == `WDT_STAT_OFS
					|| int_rd || s_axi_araddr == `WDT_INT_MASK_OFS) ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// sticky events; a new event in the read cycle survives
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			int_stat <= 2'b00;
		end else begin
			int_stat <= (int_rd ? 2'b00 : int_stat)
				| {expire & sleep_active, expire & ~sleep_active};
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat & int_mask);
		end
	end

	chk_sleep_no_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
		expire && sleep_active |=> !wdt_reset_req && wake_req)
		else $error("expiry in sleep must wake, not reset");
	chk_awake_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
		expire && !sleep_active |=> wdt_reset_req && !wake_req)
		else $error("expiry while awake must reset");
	chk_clear_instr: assert property (@(posedge core_clk) disable iff (sys_rst)
		clear_watchdog_instruction |=> wdt_count == 28'h0000000)
		else $error("clear instruction did not clear counter");
	chk_disable_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
		mode == MODE_OFF |=> wdt_count == 28'h0000000 && !wdt_reset_req)
		else $error("disabled watchdog counted");
	chk_sleep_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
		$changed(sleep_active) |=> wdt_count == 28'h0000000)
		else $error("sleep transition did not clear counter");
	chk_divider_free: assert property (@(posedge core_clk) disable iff (sys_rst)
		$changed(oscillator_divider_select) && !clear_cnt && !tick && state == ST_COUNT
		|=> $stable(wdt_count))
		else $error("divider change disturbed counter");
	chk_flags_expiry: assert property (@(posedge core_clk) disable iff (sys_rst)
		expire |=> !timeout_flag && watchdog_reset_flag == $past(sleep_active))
		else $error("expiry flags not updated");
	chk_count_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
		wdt_count < limit)
		else $error("counter passed selected period");
	chk_reset_default: assert property (@(posedge core_clk)
		$past(sys_rst) |-> timeout_prescale_select == `WDT_PRESCALE_RESET)
		else $error("prescale not at two seconds after reset");
	chk_tick_space: assert property (@(posedge core_clk) disable iff (sys_rst)
		tick |=> !tick [*8])
		else $error("tick too frequent");
	cov_wake: cover property (@(posedge core_clk) wake_req);
	cov_reset: cover property (@(posedge core_clk) wdt_reset_req);
	cov_irq: cover property (@(posedge core_clk) irq);
endmodule // wdt_core
`default_nettype wire

// file: include/wdt_cfg.svh
// watchdog register offsets, field positions, reset values and timing counts
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_CTRL_OFS        8'h00
`define WDT_STAT_OFS        8'h04
`define WDT_INT_STAT_OFS    8'h08
`define WDT_INT_MASK_OFS    8'h0C
`define WDT_PRESCALE_LSB    1
`define WDT_PRESCALE_W      5
`define WDT_SWEN_BIT        0
`define WDT_PRESCALE_RESET  5'h0B
`define WDT_PRESCALE_MAX    5'h12
`define WDT_CORE_HZ         100000000
`define WDT_LFOSC_HZ        31000
`define WDT_TICK_NS         1000000
`define WDT_TICK_CYCLES     (`WDT_TICK_NS / (1000000000 / `WDT_CORE_HZ))
`define WDT_STAT_TIMEOUT    0
`define WDT_STAT_POWERDOWN  1
`define WDT_STAT_WDRESET    2
`define WDT_INT_EXPIRE      0
`define WDT_INT_WAKE        1
`endif

// file: include/wdt_pkg.sv
// watchdog shared types
package wdt_pkg;
	typedef enum logic [1:0] {
		MODE_OFF      = 2'b00,
		MODE_SOFTWARE = 2'b01,
		MODE_AWAKE    = 2'b10,
		MODE_ALWAYS   = 2'b11
	} wdt_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_COUNT = 2'b01,
		ST_FIRED = 2'b10
	} wdt_state_t;
endpackage

// file: hdl/wdt_tick_gen.sv
// millisecond tick enable derived from the core clock
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_tick_gen #(
	parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	output var  logic tick
);
	logic [19:0] div_cnt;

	// free running; does not depend on the core divider select
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_cnt <= 20'h00000;
			tick    <= 1'b0;
		end else if (div_cnt == 20'(TICK_CYCLES - 1)) begin
			div_cnt <= 20'h00000;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 20'h00001;
			tick    <= 1'b0;
		end
	end
endmodule // wdt_tick_gen
`default_nettype wire

// file: verif/watchdog_clear_and_sleep_tb.sv
// self-checking bench for the watchdog core
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module watchdog_clear_and_sleep_tb;
	logic        core_clk, sys_rst, clear_watchdog_instruction, sleep_active, osc_fail;
	logic [1:0]  watchdog_mode_config, s_axi_bresp, s_axi_rresp;
	logic [3:0]  oscillator_divider_select, s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        wdt_reset_req, wake_req, irq;
	int          num_errors, samples_checked, seen_rst, seen_wake;
	// shortened tick so that expiries fit a short run
	localparam int TICK_CYCLES = 100;

	wdt_core #(.TICK_CYCLES(TICK_CYCLES)) DUT (.core_clk, .sys_rst, .watchdog_mode_config,
		.clear_watchdog_instruction,
		.sleep_active, .osc_fail, .oscillator_divider_select, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.wdt_reset_req, .wake_req, .irq);

	always #5 core_clk = ~core_clk;

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(logic [31:0] got, logic [31:0] exp, string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic hang();
		num_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		complete_run();
	endtask

	task automatic wait_hi(ref logic s);
		int n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (s !== 1'h1 && n < 64);
		if (s !== 1'h1)
			hang();
	endtask

	task automatic reg_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		bit ad = 0;
		bit wd = 0;
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		for (int n = 0; n < 64 && !(ad && wd); n++) begin
			@(posedge core_clk);
			if (!ad && s_axi_awready === 1'h1) begin
				s_axi_awvalid <= 1'h0;
				ad = 1;
			end
			if (!wd && s_axi_wready === 1'h1) begin
				s_axi_wvalid <= 1'h0;
				wd = 1;
			end
		end
		if (!(ad && wd))
			hang();
		s_axi_bready <= 1'h1;
		wait_hi(s_axi_bvalid);
		s_axi_bready <= 1'h0;
		check(s_axi_bresp, er, "write response");
	endtask

	task automatic reg_rd(logic [7:0] a, logic [31:0] e, logic [1:0] er, string w);
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		wait_hi(s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready  <= 1'h1;
		wait_hi(s_axi_rvalid);
		s_axi_rready  <= 1'h0;
		check(s_axi_rdata, e, w);
		check(s_axi_rresp, er, "read response");
	endtask

	// counts both expiry pulses, optionally stops at the first wanted one
	task automatic watch(int lim, bit ur, bit uw);
		seen_rst = 0;
		seen_wake = 0;
		repeat (lim) begin
			@(posedge core_clk);
			seen_rst += int'(wdt_reset_req === 1'h1);
			seen_wake += int'(wake_req === 1'h1);
			if ((ur && seen_rst > 0) || (uw && seen_wake > 0))
				return;
		end
		if (ur || uw)
			hang();
	endtask

	task automatic reset_chk();
		@(posedge core_clk);
		watchdog_mode_config <= 2'h0;
		sys_rst <= 1'h1;
		repeat (3) @(posedge core_clk);
		check({wdt_reset_req, wake_req, irq}, 3'h0, "outputs in reset");
		sys_rst <= 1'h0;
		reg_rd(`WDT_CTRL_OFS, 32'(`WDT_PRESCALE_RESET) << `WDT_PRESCALE_LSB, 2'h0, "ctrl");
		reg_rd(`WDT_STAT_OFS, 32'h007, 2'h0, "status");
		reg_rd(`WDT_INT_STAT_OFS, 32'h0, 2'h0, "events");
		reg_rd(`WDT_INT_MASK_OFS, 32'h0, 2'h0, "mask");
		reg_rd(8'h10, 32'h0, 2'h2, "unmapped");
	endtask

	task automatic modes_chk();
		logic [3:0] cfg [6] = '{4'h0, 4'h4, 4'h7, 4'h8, 4'h9, 4'hD};
		logic [5:0] act = 6'h2C;
		for (int i = 0; i < 6; i++) begin
			watchdog_mode_config <= cfg[i][3:2];
			sleep_active <= cfg[i][0];
			reg_wr(`WDT_CTRL_OFS, {26'h0, 5'h0B, cfg[i][1]}, 2'h0);
			reg_rd(`WDT_STAT_OFS, {23'h0, act[i], 8'h07}, 2'h0, "active");
		end
		reg_wr(8'h10, 32'h3F, 2'h2);
		reg_rd(`WDT_CTRL_OFS, 32'h16, 2'h0, "ctrl kept");
	endtask

	task automatic awake_exp();
		int n;
		watchdog_mode_config <= 2'h1;
		sleep_active <= 1'h0;
		reg_wr(`WDT_INT_MASK_OFS, 32'h3, 2'h0);
		reg_wr(`WDT_CTRL_OFS, 32'h1, 2'h0);
		watch(300, 1, 0);
		check(seen_wake, 0, "wake while awake");
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wdt_reset_req !== 1'h1 && n < 300);
		check(n, TICK_CYCLES, "expiry period");
		repeat (2) @(posedge core_clk);
		check(irq, 1'h1, "irq raised");
		reg_rd(`WDT_STAT_OFS, 32'h102, 2'h0, "flags awake");
		reg_rd(`WDT_INT_STAT_OFS, 32'h1, 2'h0, "event awake");
		repeat (2) @(posedge core_clk);
		check(irq, 1'h0, "irq cleared");
		reg_wr(`WDT_INT_MASK_OFS, 32'h1, 2'h0);
	endtask

	task automatic sleep_exp();
		watchdog_mode_config <= 2'h3;
		sleep_active <= 1'h1;
		watch(300, 0, 1);
		check(seen_rst, 0, "reset in sleep");
		repeat (2) @(posedge core_clk);
		check(irq, 1'h0, "masked event");
		reg_rd(`WDT_STAT_OFS, 32'h104, 2'h0, "flags asleep");
		reg_rd(`WDT_INT_STAT_OFS, 32'h2, 2'h0, "event asleep");
		sleep_active <= 1'h0;
	endtask

	// clears spaced well under two ticks must keep the 200-cycle period from expiring
	task automatic clear_chk();
		reg_wr(`WDT_CTRL_OFS, 32'h2, 2'h0);
		for (int i = 0; i < 6; i++) begin
			watch(60, 0, 0);
			check(seen_rst + seen_wake, 0, "early expiry");
			case (i % 4)
				0: clear_watchdog_instruction <= 1'h1;
				1: osc_fail <= 1'h1;
				2: watchdog_mode_config <= 2'h0;
				default: sleep_active <= 1'h1;
			endcase
			@(posedge core_clk);
			clear_watchdog_instruction <= 1'h0;
			osc_fail <= 1'h0;
			watchdog_mode_config <= 2'h3;
			sleep_active <= 1'h0;
		end
		seen_rst = 0;
		for (int i = 0; i < 6 && seen_rst == 0; i++) begin
			oscillator_divider_select <= 4'(i + 1);
			watch(60, 0, 0);
		end
		check(seen_rst, 1, "expiry despite divider change");
	endtask

	initial begin
		core_clk = 1'h0;
		sys_rst = 1'h1;
		{clear_watchdog_instruction, sleep_active, osc_fail} = 3'h0;
		watchdog_mode_config = 2'h0;
		oscillator_divider_select = 4'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awaddr, s_axi_araddr} = 16'h0000;
		s_axi_wdata = 32'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		num_errors = 0;
		samples_checked = 0;
		reset_chk();
		modes_chk();
		awake_exp();
		sleep_exp();
		clear_chk();
		reset_chk();
		complete_run();
	end
endmodule // watchdog_clear_and_sleep_tb
`default_nettype wire
